// ---- include/sep_pkg.sv ----
// Shared constants, types and helpers for the serial expansion port
package sep_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_SERIAL_CONTROL_CH0 = 10'h060;
	localparam logic [9:0] IDX_SERIAL_STATUS_CH0 = 10'h061;
	localparam logic [9:0] IDX_SERIAL_SHIFT_DATA_CH0 = 10'h062;
	localparam logic [9:0] IDX_SERIAL_CONTROL_CH1 = 10'h064;
	localparam logic [9:0] IDX_SERIAL_STATUS_CH1 = 10'h065;
	localparam logic [9:0] IDX_SERIAL_SHIFT_DATA_CH1 = 10'h066;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int F_FAULT_DISABLE = 7;
	localparam int F_ENABLE = 6;
	localparam int F_BIT_ORDER = 5;
	localparam int F_MASTER = 4;
	localparam int F_POLARITY = 3;
	localparam int F_PHASE = 2;
	localparam int F_RATE_HI = 1;
	localparam int F_RATE_LO = 0;
	localparam int S_XFER_DONE = 7;
	localparam int S_WCOL = 6;
	localparam int S_OVF = 5;
	localparam int S_MODF = 4;
	localparam int S_RX_DONE = 3;
	localparam int S_TX_DONE = 2;
	localparam int S_AUTO_MASK = 1;
	localparam int S_DMA_MODE = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h04;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] CONTROL_READ_MASK = 8'h7f;
	localparam logic [7:0] DISABLED_DATA = 8'h00;
	localparam logic [3:0] LAST_EDGE = 4'hf;
	localparam logic [5:0] DIV_BY [4] = '{6'h02, 6'h04, 6'h08, 6'h20};

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SEL_NONE, SEL_CONTROL, SEL_STATUS, SEL_DATA} reg_sel_t;
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD} shift_state_t;
	typedef struct packed {logic sclk; logic mosi; logic miso; logic ss_n;} port_in_t;
	typedef struct packed {
		logic sclk_o; logic sclk_oe; logic mosi_o; logic mosi_oe; logic miso_o; logic miso_oe;
	} port_out_t;
	typedef struct packed {
		logic mode_fault_irq; logic error_irq; logic receive_irq; logic transmit_irq;
	} irq_t;
	typedef struct packed {
		logic hit; logic write; reg_sel_t sel; logic [7:0] wdata; logic [7:0] seen;
	} chan_req_t;
	localparam port_in_t PINS_IDLE = 4'h1;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] half_period(input logic [1:0] rate);
		return 5'(DIV_BY[rate] >> 1);
	endfunction : half_period

	function automatic logic out_bit(input logic [7:0] s, input logic lsb_first);
		return lsb_first ? s[0] : s[7];
	endfunction : out_bit

	function automatic logic [7:0] shift_in(input logic [7:0] s, input logic lsb_first,
		input logic b);
		return lsb_first ? {b, s[7:1]} : {s[6:0], b};
	endfunction : shift_in

	function automatic reg_sel_t decode_reg(input logic [9:0] idx, input logic [9:0] ctl,
		input logic [9:0] sts, input logic [9:0] dat);
		return idx == ctl ? SEL_CONTROL : idx == sts ? SEL_STATUS : idx == dat ? SEL_DATA :
			SEL_NONE;
	endfunction : decode_reg

endpackage : sep_pkg

// ---- rtl/serial_expansion_port.sv ----
// Two-channel synchronous serial expansion port with APB registers
`timescale 1ns/1ps

module serial_port_unit import sep_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire chan_req_t req,
	output logic [7:0] rdata,
	input wire port_in_t pin_in,
	output port_out_t pin_out,
	output irq_t irq
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ctrl;
	logic xfer_done, wcol, ovf, modf, rx_done, tx_done, auto_mask, dma_mode;
	logic arm_done, arm_wcol, arm_ovf, arm_modf;
	logic [7:0] shreg;
	shift_state_t st;
	logic [3:0] edge_cnt;
	logic [4:0] div_cnt;
	port_in_t meta, sync;
	logic sclk_prev;
	logic done_p, wcol_p, ovf_p, modf_p, rx_p, tx_p;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire logic en = ctrl[F_ENABLE];
	wire logic master = ctrl[F_MASTER];
	wire logic pol = ctrl[F_POLARITY];
	wire logic pha = ctrl[F_PHASE];
	wire logic lsb = ctrl[F_BIT_ORDER];
	wire logic [1:0] rate = ctrl[F_RATE_HI:F_RATE_LO];
	wire logic [7:0] w = req.wdata;
	wire logic slave_act = en && !master && !sync.ss_n;
	wire logic din = master ? sync.miso : sync.mosi;
	wire logic ev = master ? (st == ST_SHIFT && div_cnt == 5'h00) :
		(slave_act && (sync.sclk ^ sclk_prev) && st != ST_HOLD);
	wire logic lead = ev && !edge_cnt[0];
	wire logic trail = ev && edge_cnt[0];
	wire logic sample = pha ? trail : lead;
	wire logic change = pha ? lead : trail;
	wire logic done = trail && edge_cnt == LAST_EDGE;
	wire logic busy = st == ST_SHIFT || (slave_act && !pha);
	wire logic fault = master && !ctrl[F_FAULT_DISABLE] && !sync.ss_n;
	wire logic data_acc = req.hit && req.sel == SEL_DATA;
	wire logic data_wr = data_acc && req.write && en;
	wire logic data_rd = data_acc && !req.write && en;
	wire logic ctl_wr = req.hit && req.write && req.sel == SEL_CONTROL;
	wire logic sts_wr = req.hit && req.write && req.sel == SEL_STATUS;
	wire logic sts_rd = req.hit && !req.write && req.sel == SEL_STATUS;
	wire logic collide = data_wr && busy;
	wire logic autoshift = data_rd && dma_mode && master && auto_mask && !busy;
	wire logic start = master && !busy && !fault && (data_wr || autoshift);
	wire logic w1c = sts_wr && dma_mode;
	wire logic hold_release = st == ST_HOLD && sync.ss_n;
	wire logic [7:0] status_compat = {xfer_done, wcol, ovf && !master, modf, 4'h0};
	wire logic [7:0] status_dma = {1'b0, wcol, ovf && !master, modf, rx_done, tx_done,
		auto_mask, 1'b1};
	wire logic [7:0] status_view = dma_mode ? status_dma : status_compat;

	// Bits that do not apply read as zero
	assign rdata = req.sel == SEL_CONTROL ? (ctrl & CONTROL_READ_MASK) :
		req.sel == SEL_STATUS ? status_view :
		(req.sel == SEL_DATA && en) ? shreg : DISABLED_DATA;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= PINS_IDLE;
			sync <= PINS_IDLE;
			sclk_prev <= 1'b0;
		end else begin
			meta <= pin_in;
			sync <= meta;
			sclk_prev <= sync.sclk;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CONTROL_RESET;
		end else begin
			if (ctl_wr)
				ctrl <= w;
			// Fault wins over a control write in the same cycle
			if (fault) begin
				ctrl[F_MASTER] <= 1'b0;
				ctrl[F_ENABLE] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags: clears first, sets last so an event is never lost
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_done <= STATUS_RESET[S_XFER_DONE];
			wcol <= STATUS_RESET[S_WCOL];
			ovf <= STATUS_RESET[S_OVF];
			modf <= STATUS_RESET[S_MODF];
			rx_done <= STATUS_RESET[S_RX_DONE];
			tx_done <= STATUS_RESET[S_TX_DONE];
			auto_mask <= STATUS_RESET[S_AUTO_MASK];
			dma_mode <= STATUS_RESET[S_DMA_MODE];
			arm_done <= 1'b0;
			arm_wcol <= 1'b0;
			arm_ovf <= 1'b0;
			arm_modf <= 1'b0;
		end else begin
			if (sts_rd && !dma_mode) begin
				arm_done <= req.seen[S_XFER_DONE];
				arm_wcol <= req.seen[S_WCOL];
				arm_ovf <= req.seen[S_OVF];
				arm_modf <= req.seen[S_MODF];
			end
			if (data_acc && !dma_mode) begin
				if (arm_done)
					xfer_done <= 1'b0;
				if (arm_wcol)
					wcol <= 1'b0;
				if (arm_ovf)
					ovf <= 1'b0;
				arm_done <= 1'b0;
				arm_wcol <= 1'b0;
				arm_ovf <= 1'b0;
			end
			if (ctl_wr && !dma_mode) begin
				if (arm_modf)
					modf <= 1'b0;
				arm_modf <= 1'b0;
				if (w[F_MASTER] && !master)
					ovf <= 1'b0;
			end
			if (w1c) begin
				if (w[S_WCOL])
					wcol <= 1'b0;
				if (w[S_OVF] && !master)
					ovf <= 1'b0;
				if (w[S_MODF])
					modf <= 1'b0;
				if (w[S_RX_DONE])
					rx_done <= 1'b0;
				if (w[S_TX_DONE])
					tx_done <= 1'b0;
				auto_mask <= w[S_AUTO_MASK];
			end
			if (sts_wr)
				dma_mode <= w[S_DMA_MODE];
			if (sts_wr && dma_mode && !w[S_DMA_MODE]) begin
				rx_done <= 1'b0;
				tx_done <= 1'b0;
			end
			if (data_rd && dma_mode)
				rx_done <= 1'b0;
			if (data_wr && dma_mode)
				tx_done <= 1'b0;
			if (collide)
				wcol <= 1'b1;
			if (fault)
				modf <= 1'b1;
			if (done && !dma_mode) begin
				xfer_done <= 1'b1;
				if (!master && xfer_done)
					ovf <= 1'b1;
			end
			if (done && dma_mode) begin
				rx_done <= 1'b1;
				if (!master && rx_done)
					ovf <= 1'b1;
				// A phase-0 slave may not be rewritten until select rises
				if (master || pha)
					tx_done <= 1'b1;
			end
			if (hold_release && dma_mode)
				tx_done <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Shift engine and pins
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_IDLE;
			edge_cnt <= 4'h0;
			div_cnt <= 5'h00;
			shreg <= DATA_RESET;
			pin_out <= '0;
		end else begin
			if (data_wr && !busy)
				shreg <= w;
			if (autoshift)
				shreg <= 8'h00;
			if (sample)
				shreg <= shift_in(shreg, lsb, din);
			if (change || (edge_cnt == 4'h0 && !pha)) begin
				pin_out.mosi_o <= out_bit(shreg, lsb);
				pin_out.miso_o <= out_bit(shreg, lsb);
			end
			if (st != ST_SHIFT)
				pin_out.sclk_o <= pol;
			else if (master && ev)
				pin_out.sclk_o <= !pin_out.sclk_o;
			pin_out.sclk_oe <= en && master && !fault;
			pin_out.mosi_oe <= en && master && !fault;
			pin_out.miso_oe <= slave_act;
			case (st)
				ST_IDLE: begin
					edge_cnt <= 4'h0;
					if (start) begin
						st <= ST_SHIFT;
						div_cnt <= half_period(rate);
					end else if (ev) begin
						st <= ST_SHIFT;
						edge_cnt <= 4'h1;
					end
				end
				ST_SHIFT: begin
					if (master)
						div_cnt <= div_cnt == 5'h00 ? half_period(rate) - 5'h01 :
							div_cnt - 5'h01;
					if (ev)
						edge_cnt <= edge_cnt + 4'h1;
					if (done) begin
						st <= (!master && !pha) ? ST_HOLD : ST_IDLE;
						edge_cnt <= 4'h0;
					end
					// Slave select rising mid-byte discards the partial byte
					if (!en || fault || (!master && sync.ss_n)) begin
						st <= ST_IDLE;
						edge_cnt <= 4'h0;
					end
				end
				ST_HOLD: begin
					if (sync.ss_n || !en)
						st <= ST_IDLE;
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Event pulses on flag rising edges
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{done_p, wcol_p, ovf_p, modf_p, rx_p, tx_p} <= 6'h00;
			irq <= '0;
		end else begin
			{done_p, wcol_p, ovf_p, modf_p, rx_p, tx_p} <= {xfer_done, wcol, ovf, modf,
				rx_done, tx_done};
			irq.mode_fault_irq <= modf && !modf_p;
			irq.error_irq <= dma_mode ? (!master && ((wcol && !wcol_p && !auto_mask) ||
				(ovf && !ovf_p && auto_mask))) : (xfer_done && !done_p);
			irq.receive_irq <= dma_mode && rx_done && !rx_p;
			irq.transmit_irq <= dma_mode && tx_done && !tx_p;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	data_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(req.sel == SEL_DATA && !en) |-> rdata == 8'h00) else $error("data not zero when off");
	wcol_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		collide |=> wcol) else $error("collision flag not set");
	wcol_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
		(w1c && wcol && !w[S_WCOL]) |=> wcol) else $error("collision flag cleared by zero");
	fault_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault |=> (modf && !ctrl[F_MASTER] && !ctrl[F_ENABLE] && !pin_out.sclk_oe &&
		!pin_out.mosi_oe)) else $error("mode fault not handled");
	fault_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(fault && !modf) |=> ##1 irq.mode_fault_irq) else $error("no mode fault pulse");
	byte_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		(start && !fault) |=> st == ST_SHIFT ##[16:600] st != ST_SHIFT)
		else $error("master byte length wrong");
	idle_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st != ST_SHIFT) |=> pin_out.sclk_o == $past(pol)) else $error("clock idle level");
	auto_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		(autoshift && !fault) |=> (st == ST_SHIFT && shreg == 8'h00))
		else $error("automatic shift not started");
	rx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(data_rd && dma_mode && !done) |=> !rx_done) else $error("receive flag kept");
	ovf_compat_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done && !dma_mode && !master && xfer_done) |=> ovf) else $error("overflow missed");

endmodule : serial_port_unit

// Notes on behaviour
// - Bit 7 set disables mode fault detection
// - Port off: data writes ignored, reads zero
// - Bit order zero sends MSB first
// - Master select: zero slave, one master
// - Polarity chooses clock idle level
// - Master divides by 2, 4, 8, 32
// - Transfer flag: set at end, read-then-access clear
// - Write during shift: collision flag, shift untouched
// - DMA collision flag write-one-clear, slave error event
// - Compat slave overflow when done flag pending
// - DMA slave overflow when receive flag pending
// - Inapplicable status bits read zero, ignore writes
// - Mode fault: flag, tri-state, drop master, enable
// - Mode fault clear: read-then-control-write or write-one
// - Receive flag after eight clocks, three clears
// - Transmit flag when byte out, three clears
// - Autoshift master read clears data, starts byte
// - Master data write starts transfer
// - Phase zero samples on first edge
// - Phase one samples on second edge
// - Master makes eight clock cycles per byte
// - Unselected slave ignores clock, output off
module serial_expansion_port import sep_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire port_in_t pins_in [2],
	output port_out_t pins_out [2],
	output irq_t irqs [2]
);
	// ----------------------------------------------------------------
	// APB decode; read data is registered in the setup cycle, so no wait state
	// ----------------------------------------------------------------
	wire logic [9:0] idx = paddr[11:2];
	wire reg_sel_t sel0 = decode_reg(idx, IDX_SERIAL_CONTROL_CH0, IDX_SERIAL_STATUS_CH0,
		IDX_SERIAL_SHIFT_DATA_CH0);
	wire reg_sel_t sel1 = decode_reg(idx, IDX_SERIAL_CONTROL_CH1, IDX_SERIAL_STATUS_CH1,
		IDX_SERIAL_SHIFT_DATA_CH1);
	wire logic setup = psel && !penable && !pready;
	wire logic complete = psel && penable && pready;
	wire logic mapped = sel0 != SEL_NONE || sel1 != SEL_NONE;
	wire chan_req_t req0 = '{hit: complete && sel0 != SEL_NONE, write: pwrite, sel: sel0,
		wdata: pwdata[7:0], seen: prdata[7:0]};
	wire chan_req_t req1 = '{hit: complete && sel1 != SEL_NONE, write: pwrite, sel: sel1,
		wdata: pwdata[7:0], seen: prdata[7:0]};
	logic [7:0] rdata0, rdata1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup)
				prdata <= {24'h000000, sel0 != SEL_NONE ? rdata0 : rdata1};
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	serial_port_unit u_ch0 (
		.pclk(pclk),
		.presetn(presetn),
		.req(req0),
		.rdata(rdata0),
		.pin_in(pins_in[0]),
		.pin_out(pins_out[0]),
		.irq(irqs[0])
	);

	serial_port_unit u_ch1 (
		.pclk(pclk),
		.presetn(presetn),
		.req(req1),
		.rdata(rdata1),
		.pin_in(pins_in[1]),
		.pin_out(pins_out[1]),
		.irq(irqs[1])
	);

endmodule : serial_expansion_port

// ---- sim/remote_spi_slave.sv ----
// Behavioural far-side slave that answers a channel set up as master
`timescale 1ns/1ps

module remote_spi_slave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic clock_polarity_select,
	input wire logic clock_phase_select,
	input wire logic lsb_first,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx,
	output logic [4:0] edges,
	output logic [7:0] gap
);
	// ----
	// Bit selection
	// ----
	logic last_sclk;
	logic [7:0] run;
	logic [2:0] idx;
	logic cur;
	assign idx = clock_phase_select ? 3'((edges - {4'h0, |edges}) >> 1) : 3'(edges >> 1);
	assign cur = lsb_first ? tx[idx] : tx[3'd7 - idx];
	// After the frame the line no longer holds the last bit
	assign miso = edges > 5'd15 ? ~(lsb_first ? tx[7] : tx[0]) : cur;

	// ----
	// Edge tracking
	// ----
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_sclk <= 1'b0;
			edges <= 5'd0;
			run <= 8'h00;
			gap <= 8'h00;
			rx <= 8'h00;
		end else if (clr) begin
			last_sclk <= sclk;
			edges <= 5'd0;
			run <= 8'h00;
		end else begin
			last_sclk <= sclk;
			run <= run + 8'h01;
			if (sclk != last_sclk) begin
				edges <= edges + 5'd1;
				gap <= run + 8'h01;
				run <= 8'h00;
				if ((sclk != clock_polarity_select) != clock_phase_select) begin
					rx <= lsb_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
				end
			end
		end
	end
endmodule : remote_spi_slave

// ---- sim/tb.sv ----
// Self-checking bench for the two-channel serial expansion port
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb;
	import sep_pkg::*;
	// ----
	// Signals
	// ----
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	port_in_t pins_in [2];
	port_out_t pins_out [2];
	irq_t irqs [2];
	logic ssn [2] = '{1'b1, 1'b1};
	logic pclr [2] = '{1'b0, 1'b0};
	logic [7:0] ptx [2] = '{8'h00, 8'h00};
	logic [7:0] prx [2];
	logic [4:0] pedges [2];
	logic [7:0] pgap [2];
	logic pmiso [2];
	logic [7:0] cfg [2] = '{8'h04, 8'h04};
	logic [7:0] seed = 8'h06;
	logic msclk = 1'b0;
	logic mmosi = 1'b0;
	int unsigned nirq [2][4] = '{default: 0};
	int checks = 0;
	int miscompares = 0;
	int cycles = 0;

	always #25 pclk = ~pclk;

	serial_expansion_port u_serial_expansion_port (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out), .irqs(irqs));

	for (genvar g = 0; g < 2; g++) begin : far
		assign pins_in[g] = '{sclk: g != 0 && msclk, mosi: g != 0 && mmosi, miso: pmiso[g],
			ss_n: ssn[g]};
		remote_spi_slave u_remote_spi_slave (.pclk(pclk), .presetn(presetn), .clr(pclr[g]),
			.sclk(pins_out[g].sclk_o), .mosi(pins_out[g].mosi_o), .clock_polarity_select(cfg[g][3]),
			.clock_phase_select(cfg[g][2]), .lsb_first(cfg[g][5]), .tx(ptx[g]), .miso(pmiso[g]),
			.rx(prx[g]), .edges(pedges[g]), .gap(pgap[g]));
	end

	always @(posedge pclk) begin
		cycles++;
		for (int c = 0; c < 2; c++)
			for (int k = 0; k < 4; k++)
				if (irqs[c][k] === 1'b1) nirq[c][k]++;
		if (cycles == 30000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ----
	// Helpers
	// ----
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	function automatic logic [7:0] exp_half(input logic [1:0] r);
		return r == 2'b00 ? 8'h01 : r == 2'b01 ? 8'h02 : r == 2'b10 ? 8'h04 : 8'h10;
	endfunction : exp_half

	function automatic logic [11:0] base(input int c);
		return c != 0 ? 12'h190 : 12'h180;
	endfunction : base

	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic err);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) miscompares++;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		repeat (4) @(posedge pclk);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] q;
		logic e;
		apb(1'b0, a, 8'h00, q, e);
		`CHK(q, exp)
	endtask : rd

	task automatic wait_flag(input int ch, input int pos, output logic [7:0] s);
		logic e;
		int n = 0;
		s = 8'h00;
		while (s[pos] !== 1'b1 && n < 200) begin
			apb(1'b0, base(ch) + 12'h4, 8'h00, s, e);
			n++;
		end
	endtask : wait_flag

	// Remote master for channel 1: mode 0, MSB first, slow enough for the synchronisers
	task automatic slave_byte(input logic [7:0] d, output logic [7:0] got);
		for (int j = 7; j >= 0; j--) begin
			mmosi <= d[j];
			repeat (8) @(posedge pclk);
			got[j] = pins_out[1].miso_o;
			msclk <= 1'b1;
			repeat (8) @(posedge pclk);
			msclk <= 1'b0;
		end
		repeat (8) @(posedge pclk);
	endtask : slave_byte

	task automatic xfer(input int ch, input logic [7:0] ctl, input logic dma, input logic coll);
		logic [7:0] b;
		logic [7:0] s;
		int unsigned er;
		b = seed;
		seed = lfsr_next(seed);
		ptx[ch] <= seed;
		seed = lfsr_next(seed);
		cfg[ch] <= ctl;
		wr(base(ch), ctl);
		pclr[ch] <= 1'b1;
		@(posedge pclk);
		pclr[ch] <= 1'b0;
		er = nirq[ch][dma ? 1 : 2];
		wr(base(ch) + 12'h8, b);
		if (coll) wr(base(ch) + 12'h8, ~b);
		wait_flag(ch, dma ? 3 : 7, s);
		// Let the event pulse reach its counter before the count is compared
		repeat (2) @(posedge pclk);
		`CHK(s, dma ? {1'b0, coll, 6'h0d} : {1'b1, coll, 6'h00})
		`CHK(pedges[ch], 5'd16)
		`CHK(pgap[ch], exp_half(ctl[1:0]))
		`CHK(prx[ch], b)
		`CHK(pins_out[ch].sclk_o, ctl[3])
		`CHK(nirq[ch][dma ? 1 : 2], er + 1)
		rd(base(ch) + 12'h8, ptx[ch]);
		if (dma) begin
			wr(base(ch) + 12'h4, 8'h01);
			rd(base(ch) + 12'h4, {1'b0, coll, 6'h05});
			wr(base(ch) + 12'h4, {1'b0, coll, 6'h05});
			rd(base(ch) + 12'h4, 8'h01);
		end else begin
			rd(base(ch) + 12'h4, 8'h00);
		end
	endtask : xfer

	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// ----
	// Main sequence
	// ----
	initial begin
		logic [7:0] q;
		logic e;
		int unsigned er;
		logic [7:0] d, m, got;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int c = 0; c < 2; c++) begin
			rd(base(c), 8'h04);
			rd(base(c) + 12'h4, 8'h00);
			wr(base(c) + 12'h8, 8'h5a);
			rd(base(c) + 12'h8, 8'h00);
		end
		apb(1'b0, 12'h1a0, 8'h00, q, e);
		`CHK(e, 1'b1)
		for (int i = 0; i < 8; i++)
			xfer(int'(i[2] ^ i[0]), {3'b010 | 3'(i[1]), 1'b1, i[2], i[0], 1'b1, i[0]}, 1'b0, i == 3);
		for (int c = 0; c < 2; c++) begin
			wr(base(c), 8'h00);
			wr(base(c) + 12'h4, 8'h01);
			xfer(c, c != 0 ? 8'h5e : 8'h72, 1'b1, c == 1);
		end
		wr(base(0) + 12'h4, 8'h03);
		pclr[0] <= 1'b1;
		@(posedge pclk);
		pclr[0] <= 1'b0;
		apb(1'b0, base(0) + 12'h8, 8'h00, q, e);
		wait_flag(0, 3, q);
		`CHK(prx[0], 8'h00)
		`CHK(pedges[0], 5'd16)
		wr(base(0), 8'h00);
		wr(base(0) + 12'h4, 8'h00);
		cfg[0] <= 8'h00;
		wr(base(0), 8'hd2);
		ssn[0] <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(base(0), 8'h52);
		ssn[0] <= 1'b1;
		er = nirq[0][3];
		repeat (8) @(posedge pclk);
		wr(base(0), 8'h52);
		ssn[0] <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK(pins_out[0].mosi_oe | pins_out[0].sclk_oe, 1'b0)
		`CHK(nirq[0][3], er + 1)
		ssn[0] <= 1'b1;
		rd(base(0), 8'h02);
		rd(base(0) + 12'h4, 8'h10);
		wr(base(0), 8'h02);
		rd(base(0) + 12'h4, 8'h00);
		// Channel 1 as a compatibility-mode slave, phase 0
		wr(base(1), 8'h00);
		wr(base(1) + 12'h4, 8'h00);
		wr(base(1), 8'h40);
		d = seed;
		seed = lfsr_next(seed);
		m = seed;
		seed = lfsr_next(seed);
		wr(base(1) + 12'h8, d);
		slave_byte(8'hff, got);
		`CHK(pins_out[1].miso_oe, 1'b0)
		er = nirq[1][2];
		ssn[1] <= 1'b0;
		repeat (6) @(posedge pclk);
		`CHK(pins_out[1].miso_oe, 1'b1)
		slave_byte(m, got);
		`CHK(got, d)
		ssn[1] <= 1'b1;
		repeat (8) @(posedge pclk);
		ssn[1] <= 1'b0;
		slave_byte(seed, got);
		`CHK(got, m)
		ssn[1] <= 1'b1;
		rd(base(1) + 12'h4, 8'ha0);
		rd(base(1) + 12'h8, seed);
		rd(base(1) + 12'h4, 8'h00);
		`CHK(nirq[1][2], er + 1)
		for (int c = 0; c < 2; c++)
			`CHK(nirq[c][0], c != 0 ? 1 : 2)
		print_verdict();
	end
endmodule : tb
